// ==== ttk_pkg.sv ====
// Purpose: shared constants and types for the telemetry timestamp keeper
// Assumes: 40-bit time = 32 seconds, 3 tick number, 4 counter, 1 quality
// Notes:   low five bits carry no sub-tick timing
package ttk_pkg;
    localparam int TIME_W      = 40;
    localparam int SEC_W       = 32;
    localparam int TICK_W      = 3;
    localparam int PKT_W       = 4;
    localparam int TICK_LSB    = 5;
    localparam int PKT_LSB     = 1;
    localparam int QUAL_BIT    = 0;
    localparam int LOW_CLR_W   = 16;
    localparam int UPPER_W     = 24;
    localparam int TAG_SEC_W   = 13;
    localparam int UPD_DELAY   = 9;
    localparam logic [3:0] REG_ARM   = 4'h0;
    localparam logic [3:0] REG_TIMEH = 4'h1;
    localparam logic [3:0] REG_TIMEL = 4'h2;
    localparam logic [3:0] REG_STAT  = 4'h3;
    localparam logic [7:0] LOW_BYTE_TICK1 = 8'h20;
    localparam logic [7:0] LOW_BYTE_ZERO  = 8'h00;
    localparam logic [2:0] TICK_LAST      = 3'h7;
    localparam logic [2:0] TICK_DELIVER   = 3'h6;
    localparam logic [3:0] PKT_FIRST      = 4'h1;
    localparam int TICK_MS     = 125;
    localparam int CLK_NS      = 25;
    localparam int TICK_CYCLES = (TICK_MS * 1000000) / CLK_NS;
endpackage

// ==== ttk_link_if.sv ====
// Purpose: link between primary keeper and a follower
// Assumes: one clock, tick is a one-cycle pulse
// Notes:   none
`timescale 1ns/1ps
interface ttk_link_if;
    logic        tickPulse;
    logic        frameAlignPulse;
    logic        upperValid;
    logic [23:0] upperBits;
    modport primary  (output tickPulse, output frameAlignPulse,
                      output upperValid, output upperBits);
    modport follower (input tickPulse, input frameAlignPulse,
                      input upperValid, input upperBits);
endinterface

// ==== ttk_time_adv.sv ====
// Purpose: advance a 40-bit time by one tick
// Assumes: combinational
// Notes:   tick number wraps 7 to 0 and carries into seconds
`timescale 1ns/1ps
module ttk_time_adv (
    input  wire logic [39:0] timeIn,
    output logic      [39:0] timeOut
);
    logic [2:0]  tick;
    logic [31:0] sec;
    always_comb begin
        tick = timeIn[ttk_pkg::TICK_LSB +: ttk_pkg::TICK_W];
        sec  = timeIn[ttk_pkg::TIME_W-1 -: ttk_pkg::SEC_W];
        timeOut = timeIn;
        if (tick == ttk_pkg::TICK_LAST) begin
            sec = sec + 32'h1;
        end
        tick = tick + 3'h1;
        timeOut[ttk_pkg::TIME_W-1 -: ttk_pkg::SEC_W] = sec;
        timeOut[ttk_pkg::TICK_LSB +: ttk_pkg::TICK_W] = tick;
    end
endmodule

// ==== ttk_primary.sv ====
// Purpose: primary keeper: time, craft updates, frame-align generator
// Assumes: craftTickIn and secLoad are from the bus interface pins
// Notes:   tick and seconds strobes are synchronised before use
`timescale 1ns/1ps
// Function
// - resolution one tick, low five bits zero; here bits 4:1 hold the counter, bit 0 quality
// - seconds loaded whole from craft
// - craft delivers seconds during tick six
// - tick number in top three low-byte bits
// - housekeeping, low rate: counter zero
// - high rate counter increments from one
// - port write arms pulse, next tick
// - option: pulse on second tick
// - pulse timed by counting tick edges
// - follower clears low 16 on pulse
// - follower advances before testing pulse
// - time advances one tick per period
// - primary sends upper 24 bits later
// - follower loads 0x20 on pulse
// - missed update sets quality flag
// - follower quality flag always one
// - tag is 13 seconds, 3 tick
// - seconds are upper 32 bits
module ttk_primary (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        craftTickIn,
    input  wire logic        secLoad,
    input  wire logic [31:0] secValue,
    input  wire logic [3:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdata,
    input  wire logic        recordFormat,
    input  wire logic        recordHighRate,
    output logic      [39:0] recordStamp,
    output logic      [15:0] miniTag,
    ttk_link_if.primary      link
);
    localparam logic [3:0] A_ARM   = ttk_pkg::REG_ARM;
    localparam logic [3:0] A_TIMEH = ttk_pkg::REG_TIMEH;
    localparam logic [3:0] A_TIMEL = ttk_pkg::REG_TIMEL;
    localparam logic [3:0] A_STAT  = ttk_pkg::REG_STAT;

    typedef enum logic [2:0] {
        TTK_IDLE  = 3'b001,
        TTK_ARMED = 3'b010,
        TTK_PULSE = 3'b100
    } ttk_gen_t;

    typedef struct packed {
        logic [1:0]  tickSync;
        logic [1:0]  loadSync;
        logic        tickPrev;
        logic        loadPrev;
        logic [31:0] secMeta;
        logic [31:0] secSync;
        logic [31:0] secLatch;
        logic [39:0] timeNow;
        logic        gotUpdate;
        ttk_gen_t    gen;
        logic [1:0]  edgesLeft;
        logic [3:0]  updCount;
        logic        updValid;
        logic [39:0] stamp;
        logic [15:0] tag;
        logic [31:0] rdata;
    } ttk_prim_t;

    ttk_prim_t   s_r;
    ttk_prim_t   s_nxt;
    logic [39:0] advTime;
    logic        tickEdge;
    logic        loadEdge;

    ttk_time_adv u_adv (
        .timeIn  (s_r.timeNow),
        .timeOut (advTime)
    );

    always_comb begin
        s_nxt = s_r;
        // ----------------------------------------
        // pin synchronisers, two stages each
        // ----------------------------------------
        s_nxt.tickSync = {s_r.tickSync[0], craftTickIn};
        s_nxt.loadSync = {s_r.loadSync[0], secLoad};
        s_nxt.secMeta  = secValue;
        s_nxt.secSync  = s_r.secMeta;
        s_nxt.tickPrev = s_r.tickSync[1];
        s_nxt.loadPrev = s_r.loadSync[1];
        tickEdge = s_r.tickSync[1] & ~s_r.tickPrev;
        loadEdge = s_r.loadSync[1] & ~s_r.loadPrev;
        s_nxt.updValid = 1'b0;
        // ----------------------------------------
        // craft seconds capture
        // ----------------------------------------
        if (loadEdge) begin
            s_nxt.secLatch  = s_r.secSync;
            s_nxt.gotUpdate = 1'b1;
        end
        // ----------------------------------------
        // tick advance
        // ----------------------------------------
        if (tickEdge) begin
            s_nxt.timeNow = advTime;
            if (s_r.timeNow[ttk_pkg::TICK_LSB +: ttk_pkg::TICK_W]
                    == ttk_pkg::TICK_LAST) begin
                if (s_r.gotUpdate) begin
                    s_nxt.timeNow[ttk_pkg::TIME_W-1 -: ttk_pkg::SEC_W] =
                        s_r.secLatch + 32'h1;
                end
                s_nxt.timeNow[ttk_pkg::QUAL_BIT] = ~s_r.gotUpdate;
                s_nxt.gotUpdate = loadEdge;
            end
            s_nxt.timeNow[ttk_pkg::PKT_LSB +: ttk_pkg::PKT_W] = 4'h0;
        end
        // ----------------------------------------
        // frame-align generator
        // ----------------------------------------
        case (s_r.gen)
            TTK_IDLE: begin
                if (regWr && regAddr == A_ARM) begin
                    s_nxt.gen = TTK_ARMED;
                    s_nxt.edgesLeft = regWdata[0] ? 2'h2 : 2'h1;
                end
            end
            TTK_ARMED: begin
                if (tickEdge) begin
                    if (s_r.edgesLeft == 2'h1) begin
                        s_nxt.gen = TTK_PULSE;
                    end
                    s_nxt.edgesLeft = s_r.edgesLeft - 2'h1;
                end
            end
            TTK_PULSE: begin
                if (tickEdge) begin
                    s_nxt.gen = TTK_IDLE;
                    s_nxt.updCount = 4'(ttk_pkg::UPD_DELAY);
                end
            end
            default: s_nxt.gen = TTK_IDLE;
        endcase
        if (tickEdge && s_r.updCount != 4'h0) begin
            s_nxt.updCount = s_r.updCount - 4'h1;
            if (s_r.updCount == 4'h1) begin
                s_nxt.updValid = 1'b1;
            end
        end
        // ----------------------------------------
        // record stamping
        // ----------------------------------------
        if (recordFormat) begin
            s_nxt.stamp = s_r.timeNow;
            s_nxt.stamp[4:1] = 4'h0;
            if (recordHighRate) begin
                if (s_r.timeNow[4:1] == 4'h0 || tickEdge) begin
                    s_nxt.stamp[4:1] = ttk_pkg::PKT_FIRST;
                end else begin
                    s_nxt.stamp[4:1] = s_r.timeNow[4:1] + 4'h1;
                end
                if (!tickEdge) begin
                    s_nxt.timeNow[4:1] = s_nxt.stamp[4:1];
                end
            end
            s_nxt.tag = {s_r.timeNow[ttk_pkg::TICK_LSB + ttk_pkg::TICK_W
                                     +: ttk_pkg::TAG_SEC_W],
                         s_r.timeNow[7:5]};
        end
        // ----------------------------------------
        // register read, one cycle later
        // ----------------------------------------
        s_nxt.rdata = 32'h0;
        if (regRd) begin
            case (regAddr)
                A_ARM:   s_nxt.rdata = {29'h0, s_r.gen};
                A_TIMEH: s_nxt.rdata = s_r.timeNow[39:8];
                A_TIMEL: s_nxt.rdata = {24'h0, s_r.timeNow[7:0]};
                A_STAT:  s_nxt.rdata = {30'h0, s_r.gotUpdate,
                                        s_r.timeNow[0]};
                default: s_nxt.rdata = 32'h0;
            endcase
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.gen <= TTK_IDLE;
            s_r.timeNow[ttk_pkg::QUAL_BIT] <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign regRdata  = s_r.rdata;
    assign recordStamp = s_r.stamp;
    assign miniTag   = s_r.tag;
    assign link.tickPulse = s_r.tickSync[1] & ~s_r.tickPrev;
    assign link.frameAlignPulse = (s_r.gen == TTK_PULSE);
    assign link.upperValid = s_r.updValid;
    assign link.upperBits  = s_r.timeNow[39:16];
endmodule

// ==== ttk_follower.sv ====
// Purpose: follower keeper aligned by frame-align pulse
// Assumes: link signals on sys_clk from the primary
// Notes:   quality flag always one
`timescale 1ns/1ps
module ttk_follower (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        markTick1,
    output logic      [39:0] timeNow,
    ttk_link_if.follower     link
);
    logic [39:0] time_r;
    logic [39:0] time_nxt;
    logic [39:0] advTime;

    ttk_time_adv u_adv (
        .timeIn  (time_r),
        .timeOut (advTime)
    );

    always_comb begin
        time_nxt = time_r;
        if (link.tickPulse) begin
            time_nxt = advTime;
            if (link.frameAlignPulse) begin
                time_nxt[15:0] = 16'h0;
                if (markTick1) begin
                    time_nxt[7:0] = ttk_pkg::LOW_BYTE_TICK1;
                end
            end
        end
        if (link.upperValid) begin
            time_nxt[39:16] = link.upperBits;
        end
        time_nxt[ttk_pkg::QUAL_BIT] = 1'b1;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            time_r <= 40'h1;
        end else begin
            time_r <= time_nxt;
        end
    end

    assign timeNow = time_r;
endmodule

// ==== ttk_link_assertions.sv ====
// Purpose: link checks between primary and follower
// Assumes: one clock, sync active-high reset
// Notes:   sees link signals only
`timescale 1ns/1ps
module ttk_link_assertions (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        tickPulse,
    input wire logic        frameAlignPulse,
    input wire logic        upperValid,
    input wire logic [23:0] upperBits
);
    // ----------
    // checks
    // ----------
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_align_rise_tick: assert property (
        $rose(frameAlignPulse) |-> $past(tickPulse))
        else $error("align rose off a tick");
    a_align_fall_tick: assert property (
        $fell(frameAlignPulse) |-> $past(tickPulse))
        else $error("align fell off a tick");
    a_align_holds: assert property (
        frameAlignPulse && !tickPulse |=> frameAlignPulse)
        else $error("align dropped mid period");
    a_align_one_period: assert property (
        frameAlignPulse && tickPulse |=> !frameAlignPulse)
        else $error("align longer than a period");
    a_tick_single: assert property (
        tickPulse |=> !tickPulse)
        else $error("tick wider than a cycle");
    a_update_single: assert property (
        upperValid |=> !upperValid)
        else $error("update wider than a cycle");
    a_update_quiet: assert property (
        upperValid |-> !frameAlignPulse)
        else $error("update during align");
    a_upper_on_tick: assert property (
        $changed(upperBits) |-> $past(tickPulse))
        else $error("upper bits moved off a tick");
    cover property ($rose(frameAlignPulse));
    cover property (frameAlignPulse && tickPulse);
    cover property (upperValid);
endmodule

// ==== telemetry_timestamp_keeper_tb.sv ====
// Purpose: self-checking bench for primary and follower keepers
// Assumes: tick pin period of 41 clocks
// Notes:   bench tracks seconds, tick and quality itself
`timescale 1ns/1ps
module telemetry_timestamp_keeper_tb;
    logic        sys_clk, rst, craftTickIn, secLoad, regWr, regRd;
    logic        recordFormat, recordHighRate, markTick1, mQual, ldPend;
    logic [2:0]  mTick;
    logic [3:0]  regAddr;
    logic [15:0] miniTag;
    logic [31:0] secValue, regWdata, regRdata, mSec, ldVal, rv;
    logic [39:0] recordStamp, timeNow;
    int          failures, checked, i, updCnt, updBase;

    ttk_link_if lnk ();
    ttk_primary i_ttk_primary (.sys_clk, .rst, .craftTickIn, .secLoad,
        .secValue, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .recordFormat, .recordHighRate, .recordStamp, .miniTag, .link(lnk));
    ttk_follower i_ttk_follower (.sys_clk, .rst, .markTick1, .timeNow,
        .link(lnk));
    ttk_link_assertions i_chk (.sys_clk, .rst, .tickPulse(lnk.tickPulse),
        .frameAlignPulse(lnk.frameAlignPulse), .upperValid(lnk.upperValid),
        .upperBits(lnk.upperBits));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (rst)
            updCnt <= 0;
        else if (lnk.upperValid === 1'b1)
            updCnt <= updCnt + 1;
    end

    // ----------
    // tasks
    // ----------
    task automatic chk(input string what, input logic [39:0] got, exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 v = regRdata;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    // one tick edge on the pin, model follows
    task automatic tick();
        @(posedge sys_clk);
        craftTickIn <= 1'b1;
        repeat (20) @(posedge sys_clk);
        craftTickIn <= 1'b0;
        repeat (20) @(posedge sys_clk);
        mTick = mTick + 3'h1;
        if (mTick == 3'h0) begin
            mSec = ldPend ? ldVal + 32'h1 : mSec + 32'h1;
            mQual = !ldPend;
            ldPend = 1'b0;
        end
    endtask
    task automatic chkTime();
        rd(4'h1, rv);
        chk("seconds", 40'(rv), 40'(mSec));
        rd(4'h2, rv);
        chk("low byte", 40'(rv), 40'({mTick, 4'h0, mQual}));
        rd(4'h3, rv);
        chk("quality", 40'(rv[0]), 40'(mQual));
    endtask
    task automatic rec(input logic hr, input logic [3:0] pkt);
        @(posedge sys_clk);
        recordHighRate <= hr;
        recordFormat <= 1'b1;
        @(posedge sys_clk);
        recordFormat <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 chk("stamp", recordStamp, {mSec, mTick, pkt, mQual});
        chk("tag", 40'(miniTag), 40'({mSec[12:0], mTick}));
    endtask
    task automatic align(input logic [39:0] exp);
        tick();
        chk("align", 40'(lnk.frameAlignPulse), exp);
    endtask
    task automatic tally_and_finish();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ----------
    // sequence
    // ----------
    initial begin
        {rst, craftTickIn, secLoad, regWr, regRd, recordFormat} = 6'h20;
        {recordHighRate, markTick1, ldPend, mQual} = 4'h1;
        {regAddr, secValue, regWdata, mSec, ldVal, mTick} = '0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        chkTime();
        chk("follower", timeNow, 40'h1);
        tick();
        chkTime();
        repeat (7) tick();
        chkTime();
        repeat (6) tick();
        secValue <= 32'h1234_5670;
        secLoad <= 1'b1;
        repeat (4) @(posedge sys_clk);
        secLoad <= 1'b0;
        {ldPend, ldVal} = {1'b1, 32'h1234_5670};
        rd(4'h3, rv);
        chk("update flag", 40'(rv[1]), 40'h1);
        repeat (2) tick();
        chkTime();
        rec(1'b0, 4'h0);
        rec(1'b1, 4'h1);
        rec(1'b1, 4'h2);
        wr(4'h0, 32'h0);
        align(40'h1);
        align(40'h0);
        markTick1 <= 1'b1;
        wr(4'h0, 32'h1);
        align(40'h0);
        align(40'h1);
        wr(4'h0, 32'h0);
        align(40'h0);
        align(40'h0);
        chk("follower low", 40'(timeNow[15:8]), 40'h0);
        chk("follower quality", 40'(timeNow[0]), 40'h1);
        updBase = updCnt;
        for (i = 0; i < 12 && updCnt == updBase; i++)
            tick();
        chk("update seen", 40'(updCnt - updBase), 40'h1);
        chk("follower upper", 40'(timeNow[39:16]), 40'(mSec[31:8]));
        tally_and_finish();
    end
endmodule
